// File: cscc_clock_switch.v
// Behaviour
// - Bit 6 picks CPU clock, bit 4 main
// - Old clock runs on several cycles after write
// - Bit 7 reads CPU clock status
// - Bit 5 reads main clock source status
// - Peripheral clock follows CPU clock source
// - Main source switch bounded by clock ratio
// - CPU main/sub switch bounded latency
// - Latency counted in old source cycles
// - Fractional latencies tolerate rounding up
// - High-speed clock kind fixed until reset
`include "cscc_consts.vh"
`default_nettype none

module cscc_clock_switch (
  // System
  input wire clk_sys,
  input wire arst_n,
  // Wishbone slave
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [`CSCC_ADR_W-1:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  output reg [31:0] wb_dat_o,
  output reg wb_ack_o,
  // Oscillator ticks, one-cycle enables at each source rate
  input wire ihTick,
  input wire mxTick,
  input wire subTick,
  // Derived clock enables
  output reg cpuClkEn_r,
  output reg periphClkEn_r,
  // Oscillator controls
  output reg internalOscStop_r,
  output reg mainOscStop_r,
  output reg subOscStop_r,
  output reg hsExtClock_r
);

  reg mainSel_r;
  reg cpuSel_r;
  reg hsLock_r;
  wire mainTick;
  wire mainStat;
  wire cpuTick;
  wire cpuStat;
  wire wbReq;
  wire wrByte0;
  reg [31:0] rdData;

  // Main clock: internal oscillator (A) or high-speed system clock (B)
  cscc_glitch_mux mainMux (
    .clk_sys(clk_sys),
    .arst_n(arst_n),
    .tickA(ihTick),
    .tickB(mxTick),
    .selB(mainSel_r),
    .tickOut_r(mainTick),
    .curB_r(mainStat)
  );

  // CPU clock: main clock (A) or subsystem clock (B)
  cscc_glitch_mux cpuMux (
    .clk_sys(clk_sys),
    .arst_n(arst_n),
    .tickA(mainTick),
    .tickB(subTick),
    .selB(cpuSel_r),
    .tickOut_r(cpuTick),
    .curB_r(cpuStat)
  );

  assign wbReq = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign wrByte0 = wbReq & wb_we_i & wb_sel_i[0];

  always @* begin
    rdData = 32'h0000_0000;
    if (wb_adr_i == `CSCC_ADR_CTRL) begin
      rdData[`CSCC_BIT_MAIN_SEL] = mainSel_r;
      rdData[`CSCC_BIT_MAIN_STAT] = mainStat;
      rdData[`CSCC_BIT_CPU_SEL] = cpuSel_r;
      rdData[`CSCC_BIT_CPU_STAT] = cpuStat;
    end else if (wb_adr_i == `CSCC_ADR_STOP) begin
      rdData[`CSCC_BIT_IH_STOP] = internalOscStop_r;
      rdData[`CSCC_BIT_MX_STOP] = mainOscStop_r;
      rdData[`CSCC_BIT_SUB_STOP] = subOscStop_r;
      rdData[`CSCC_BIT_HS_EXT] = hsExtClock_r;
      rdData[`CSCC_BIT_HS_LOCK] = hsLock_r;
    end
  end

  // Bus answers every access one cycle later; unmapped reads return zero
  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= wbReq;
      if (wbReq) begin
        wb_dat_o <= rdData;
      end
    end
  end

  // Status bits are read-only; writes to them are dropped
  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      mainSel_r <= `CSCC_RST_SEL;
      cpuSel_r <= `CSCC_RST_SEL;
    end else if (wrByte0 && wb_adr_i == `CSCC_ADR_CTRL) begin
      mainSel_r <= wb_dat_i[`CSCC_BIT_MAIN_SEL];
      cpuSel_r <= wb_dat_i[`CSCC_BIT_CPU_SEL];
    end
  end

  // Stop bits are passed on as written: software only stops an unused
  // oscillator, the mux never waits on a stopped source otherwise.
  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      internalOscStop_r <= `CSCC_RST_STOP;
      mainOscStop_r <= `CSCC_RST_STOP;
      subOscStop_r <= `CSCC_RST_STOP;
      hsExtClock_r <= 1'b0;
      hsLock_r <= 1'b0;
    end else if (wrByte0 && wb_adr_i == `CSCC_ADR_STOP) begin
      internalOscStop_r <= wb_dat_i[`CSCC_BIT_IH_STOP];
      mainOscStop_r <= wb_dat_i[`CSCC_BIT_MX_STOP];
      subOscStop_r <= wb_dat_i[`CSCC_BIT_SUB_STOP];
      // First write fixes crystal/external kind; only reset frees it
      if (!hsLock_r) begin
        hsExtClock_r <= wb_dat_i[`CSCC_BIT_HS_EXT];
        hsLock_r <= 1'b1;
      end
    end
  end

  // CPU and peripheral enables come from one source, so they never diverge
  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      cpuClkEn_r <= 1'b0;
      periphClkEn_r <= 1'b0;
    end else begin
      cpuClkEn_r <= cpuTick;
      periphClkEn_r <= cpuTick;
    end
  end

endmodule // cscc_clock_switch

`default_nettype wire

// File: cscc_consts.vh
`ifndef CSCC_CONSTS_VH
`define CSCC_CONSTS_VH

// Register byte addresses
`define CSCC_ADR_W 8
`define CSCC_ADR_CTRL 8'h00
`define CSCC_ADR_STOP 8'h04

// Clock select/status register fields
`define CSCC_BIT_MAIN_SEL 4
`define CSCC_BIT_MAIN_STAT 5
`define CSCC_BIT_CPU_SEL 6
`define CSCC_BIT_CPU_STAT 7

// Oscillator stop register fields
`define CSCC_BIT_IH_STOP 0
`define CSCC_BIT_MX_STOP 1
`define CSCC_BIT_SUB_STOP 2
`define CSCC_BIT_HS_EXT 4
`define CSCC_BIT_HS_LOCK 5

// Reset values: internal oscillator feeds main clock, CPU on main clock
`define CSCC_RST_SEL 1'b0
`define CSCC_RST_STOP 1'b0
`define CSCC_STOP_RST_ALL 3'h0

`endif

// File: cscc_glitch_mux.v
`default_nettype none

// Two-input switch for clock-enable streams. The old source keeps running
// until its next tick has passed; only then does the output wait for the
// first tick of the new source, so no runt or doubled period reaches the CPU.
module cscc_glitch_mux (
  // System
  input wire clk_sys,
  input wire arst_n,
  // Sources
  input wire tickA,
  input wire tickB,
  input wire selB,
  // Result
  output reg tickOut_r,
  output reg curB_r
);

  localparam [2:0] ST_RUN = 3'h1;
  localparam [2:0] ST_DRAIN = 3'h2;
  localparam [2:0] ST_ARM = 3'h4;

  reg [2:0] state_r;
  reg [2:0] state_nxt;
  wire oldTick;
  wire newTick;

  assign oldTick = curB_r ? tickB : tickA;
  assign newTick = curB_r ? tickA : tickB;

  always @* begin
    state_nxt = state_r;
    case (state_r)
      ST_RUN: begin
        if (selB != curB_r) begin
          state_nxt = ST_DRAIN;
        end
      end
      ST_DRAIN: begin
        // Last old-source cycle passes before the gate closes
        if (oldTick) begin
          state_nxt = ST_ARM;
        end
      end
      ST_ARM: begin
        // Worst case is one old period plus one new period, within the
        // rounded-up latency figures
        if (newTick) begin
          state_nxt = ST_RUN;
        end
      end
      default: begin
        state_nxt = ST_RUN;
      end
    endcase
  end

  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      state_r <= ST_RUN;
      curB_r <= `CSCC_RST_SEL;
      tickOut_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      // Status moves only once the new source has delivered its first tick
      if (state_r == ST_ARM && newTick) begin
        curB_r <= ~curB_r;
      end
      if (state_r == ST_ARM) begin
        tickOut_r <= newTick;
      end else begin
        tickOut_r <= oldTick;
      end
    end
  end

endmodule // cscc_glitch_mux

`default_nettype wire

// File: cscc_sw_assertions.sv
`default_nettype none
module cscc_sw_assertions (
  // System
  input wire logic clk_sys, arst_n,
  // Bus
  input wire logic wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i, wb_dat_o,
  // Clocks and controls
  input wire logic ihTick, mxTick, subTick, cpuClkEn_r, periphClkEn_r,
  input wire logic internalOscStop_r, mainOscStop_r, subOscStop_r, hsExtClock_r
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!arst_n);
  logic lk_r;
  wire logic rdAck = wb_ack_o && !wb_we_i;
  // Kind is frozen once software has written the stop register
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) lk_r <= 1'b0;
    else if (wb_ack_o && wb_we_i && wb_adr_i == 8'h04 && wb_sel_i[0]) lk_r <= 1'b1;
  end
  property p_per; periphClkEn_r == cpuClkEn_r; endproperty
  a_per: assert property (p_per) else $error("peripheral enable differs");
  property p_take; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o; endproperty
  a_take: assert property (p_take) else $error("ack late");
  property p_pulse; wb_ack_o |=> !wb_ack_o; endproperty
  a_pulse: assert property (p_pulse) else $error("ack too long");
  property p_unm; rdAck && wb_adr_i != 8'h00 && wb_adr_i != 8'h04 |-> wb_dat_o == 32'h0;
  endproperty
  a_unm: assert property (p_unm) else $error("unmapped read not zero");
  property p_rdst; rdAck && wb_adr_i == 8'h04 |-> wb_dat_o[4] == hsExtClock_r &&
    wb_dat_o[2:0] == {subOscStop_r, mainOscStop_r, internalOscStop_r}; endproperty
  a_rdst: assert property (p_rdst) else $error("stop register read wrong");
  property p_lock; lk_r |-> $stable(hsExtClock_r); endproperty
  a_lock: assert property (p_lock) else $error("clock kind changed");
  property p_stop; !$stable({internalOscStop_r, mainOscStop_r, subOscStop_r}) |->
    wb_ack_o && wb_we_i && wb_adr_i == 8'h04; endproperty
  a_stop: assert property (p_stop) else $error("stop bit moved alone");
  property p_src; cpuClkEn_r |-> $past(subTick, 2) || $past(ihTick | mxTick, 3);
  endproperty
  a_src: assert property (p_src) else $error("cpu enable without tick");
  c_sub: cover property (cpuClkEn_r && $past(subTick, 2));
  c_lock: cover property ($rose(lk_r));
  c_unm: cover property (rdAck && wb_adr_i == 8'h08);
endmodule // cscc_sw_assertions
bind cscc_clock_switch cscc_sw_assertions i_cscc_sw_assertions (.*);
`default_nettype wire

// File: tb.sv
`include "cscc_consts.vh"
`default_nettype none
`define CHK(n, e, s) begin check_count++; if ((s) !== (e)) begin n_mismatch++; \
  $display("mismatch %s exp %h got %h", n, e, s); end end
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys = 1'b0, arst_n = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0, subEn = 1'b0;
  logic ihTick = 1'b0, mxTick = 1'b0, subTick = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'h0;
  logic [31:0] dat = 32'h0, rd;
  wire logic [31:0] datO;
  wire logic ack, cpuEn, perEn, ihStop, mxStop, subStop, hsExt;
  int n_mismatch = 0, check_count = 0, tc = 0;
  initial forever #12.5 clk_sys = ~clk_sys;
  // Source rates: internal osc every 4, high-speed every 3, sub every 16 cycles
  always @(posedge clk_sys) begin
    tc <= tc + 1;
    ihTick <= (tc % 4 == 0);
    mxTick <= (tc % 3 == 0);
    subTick <= subEn && (tc % 16 == 0);
  end
  cscc_clock_switch i_cscc_clock_switch (.clk_sys(clk_sys), .arst_n(arst_n), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat),
    .wb_dat_o(datO), .wb_ack_o(ack), .ihTick(ihTick), .mxTick(mxTick), .subTick(subTick),
    .cpuClkEn_r(cpuEn), .periphClkEn_r(perEn), .internalOscStop_r(ihStop),
    .mainOscStop_r(mxStop), .subOscStop_r(subStop), .hsExtClock_r(hsExt));
  task automatic summarize;
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
    input logic [3:0] s);
    int k;
    @(posedge clk_sys);
    {cyc, stb, we, adr, dat, sel} <= {2'b11, w, a, d, s};
    k = 0;
    do begin @(posedge clk_sys); k++; end while (ack !== 1'b1 && k < 50);
    rd = datO;
    {cyc, stb} <= 2'b00;
    if (k >= 50) begin n_mismatch++; summarize(); end
  endtask
  // Wait the documented worst case, counted in CPU clocks
  task automatic waitCpu(input int n);
    int k, c;
    k = 0;
    c = 0;
    do begin @(posedge clk_sys); k++; if (cpuEn === 1'b1) c++; end while (c < n && k < 800);
    if (k >= 800) begin n_mismatch++; summarize(); end
  endtask
  task automatic testReg;
    wb(1'b1, `CSCC_ADR_CTRL, 32'ha0, 4'h1);
    wb(1'b0, `CSCC_ADR_CTRL, 32'h0, 4'h1);
    `CHK("ctrl", 32'h0, rd)
    wb(1'b1, 8'h08, 32'hff, 4'h1);
    wb(1'b0, `CSCC_ADR_STOP, 32'h0, 4'h1);
    `CHK("stop", 32'h0, rd)
    wb(1'b0, 8'h08, 32'h0, 4'h1);
    `CHK("unmapped", 32'h0, rd)
    $display("test reg done");
  endtask
  task automatic testCpu;
    wb(1'b1, `CSCC_ADR_CTRL, 32'h40, 4'h1);
    wb(1'b0, `CSCC_ADR_CTRL, 32'h0, 4'h1);
    `CHK("cpu held", 32'h40, rd)
    subEn <= 1'b1;
    waitCpu(9);
    wb(1'b0, `CSCC_ADR_CTRL, 32'h0, 4'h1);
    `CHK("cpu sub", 32'hc0, rd)
    wb(1'b1, `CSCC_ADR_CTRL, 32'h0, 4'h1);
    waitCpu(3);
    wb(1'b0, `CSCC_ADR_CTRL, 32'h0, 4'h1);
    `CHK("cpu main", 32'h0, rd)
    $display("test cpu done");
  endtask
  task automatic testMain;
    wb(1'b1, `CSCC_ADR_CTRL, 32'h10, 4'h1);
    waitCpu(2);
    wb(1'b0, `CSCC_ADR_CTRL, 32'h0, 4'h1);
    `CHK("main hs", 32'h30, rd)
    wb(1'b1, `CSCC_ADR_CTRL, 32'h0, 4'h1);
    waitCpu(3);
    wb(1'b0, `CSCC_ADR_CTRL, 32'h0, 4'h1);
    `CHK("main ih", 32'h0, rd)
    $display("test main done");
  endtask
  task automatic testStop;
    wb(1'b1, `CSCC_ADR_STOP, 32'h16, 4'h1);
    wb(1'b0, `CSCC_ADR_STOP, 32'h0, 4'h1);
    `CHK("stop set", 32'h36, rd)
    wb(1'b1, `CSCC_ADR_STOP, 32'h0, 4'h1);
    wb(1'b0, `CSCC_ADR_STOP, 32'h0, 4'h1);
    `CHK("kind kept", 32'h30, rd)
    wb(1'b1, `CSCC_ADR_STOP, 32'h06, 4'h0);
    wb(1'b0, `CSCC_ADR_STOP, 32'h0, 4'h1);
    `CHK("no sel", 32'h30, rd)
    wb(1'b1, `CSCC_ADR_CTRL, 32'h40, 4'h1);
    waitCpu(9);
    wb(1'b1, `CSCC_ADR_STOP, 32'h01, 4'h1);
    wb(1'b0, `CSCC_ADR_STOP, 32'h0, 4'h1);
    `CHK("ih stop", 32'h31, rd)
    $display("test stop done");
  endtask
  initial begin
    repeat (20) @(posedge clk_sys);
    arst_n <= 1'b1;
    testReg();
    testCpu();
    testMain();
    testStop();
    summarize();
  end
endmodule // tb
`default_nettype wire
